// *** bench/pcrc_dma_model.sv ***
/*
  Dma channel model feeding crc_data_in of the crc engine.
  Assumes the bench routes its strobe and data onto the register port while en is high.
*/
`timescale 1ns/1ps
module pcrc_dma_model #(
  parameter int N = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic en,
  input wire logic [3:0] gap,
  input wire logic [8*N-1:0] buf_bytes,
  input wire logic dma_req,
  output logic wr,
  output logic [7:0] wdata,
  output logic done
);
  int idx;
  logic [3:0] wait_cnt;
  // one byte per request, lowest address first, optional stall between bytes
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr <= 1'b0;
      wdata <= 8'h00;
      idx <= 0;
      wait_cnt <= 4'h0;
    end else if (wr || !en) begin
      wr <= 1'b0;
      wdata <= ~wdata; // released data is the inverted last byte
      wait_cnt <= gap;
      if (!en) idx <= 0;
    end else if (wait_cnt != 4'h0) begin
      wait_cnt <= wait_cnt - 4'h1;
      wdata <= ~wdata;
    end else if (dma_req && idx < N) begin
      wr <= 1'b1;
      wdata <= buf_bytes[8*idx +: 8];
      idx <= idx + 1;
    end
  end
  // end of transfer, stands in for the channel completion interrupt
  assign done = (idx == N) && !wr;
endmodule : pcrc_dma_model

// *** bench/tb_top.sv ***
/*
  Self-checking bench of the crc engine: register tasks, read scoreboard, dma feed.
  Assumes the engine's register map and control bits from the constants header.
*/
`timescale 1ns/1ps
`include "pcrc_defs.svh"
module tb_top;
  localparam logic [7:0] A_CT = `PCRC_ADDR_CONTROL, A_IN = `PCRC_ADDR_DATA_IN;
  logic clk = 0, rst = 1, t_wr = 0, t_rd = 0, dma_on = 0, rd_seen = 0, t_en = 1;
  logic [7:0] t_addr = 0, t_wdata = 0, t_page = `PCRC_PAGE, reg_rdata;
  logic [15:0] c, poly;
  logic [63:0] bufv = 0;
  logic [3:0] gap = 0;
  logic busy, dma_req, m_wr, m_done;
  logic [7:0] m_wdata;
  logic [15:0] exp_q[$];
  int seed = 24, fail_count = 0, cmp_count = 0, cyc = 0;
  always #2.5 clk = ~clk;
  pcrc_engine dut_u (.clk(clk), .rst(rst), .clk_en(t_en),
    .reg_page(dma_on ? `PCRC_PAGE : t_page), .reg_addr(dma_on ? A_IN : t_addr),
    .reg_wdata(dma_on ? m_wdata : t_wdata), .reg_wr(dma_on ? m_wr : t_wr),
    .reg_rd(t_rd), .reg_rdata(reg_rdata), .dma_req(dma_req), .busy(busy));
  pcrc_dma_model #(.N(8)) dma_u (.clk(clk), .rst(rst), .en(dma_on), .gap(gap),
    .buf_bytes(bufv), .dma_req(dma_req), .wr(m_wr), .wdata(m_wdata), .done(m_done));
  function automatic logic [15:0] crc8(input logic [15:0] v, input logic [7:0] b);
    for (int i = 7; i >= 0; i--) v = {v[14:0], 1'b0} ^ ((v[15] ^ b[i]) ? poly : 16'h0000);
    return v;
  endfunction : crc8
  function automatic logic [15:0] view(input logic [15:0] v, input logic [1:0] m);
    logic [15:0] r;
    for (int i = 0; i < 16; i++) r[i] = m[1] ? v[15-i] : v[i];
    return m[0] ? ~r : r;
  endfunction : view
  task automatic stop_test();
    $display("mismatches %0d, comparisons %0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [15:0] note, input logic [7:0] got);
    cmp_count++;
    if (got !== note[7:0]) begin
      fail_count++;
      $display("unexpected read of %h: expected %h, seen %h", note[15:8], note[7:0], got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    t_wr <= 1'b1;
    t_addr <= a;
    t_wdata <= d;
    @(posedge clk);
    t_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    t_rd <= 1'b1;
    t_addr <= a;
    exp_q.push_back({a, e});
    @(posedge clk);
    t_rd <= 1'b0;
  endtask : rd
  task automatic res(input logic [15:0] e);
    rd(`PCRC_ADDR_RES_LO, e[7:0]);
    rd(`PCRC_ADDR_RES_HI, e[15:8]);
  endtask : res
  task automatic idle();
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      if (busy === 1'b0) break;
    end
  endtask : idle
  task automatic feed(input logic [7:0] b);
    wr(A_IN, b);
    @(posedge clk);
    chk({8'hf0, 8'h01}, {7'h00, busy});
    c = crc8(c, b);
    idle();
  endtask : feed
  task automatic setpoly(input logic [15:0] p);
    poly = p;
    wr(`PCRC_ADDR_POLY_HI, p[15:8]);
    wr(`PCRC_ADDR_POLY_LO, p[7:0]);
  endtask : setpoly
  // read scoreboard: data stands one cycle after the strobe
  always @(posedge clk) begin
    if (rd_seen) chk(exp_q.pop_front(), reg_rdata);
    rd_seen <= t_rd;
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      stop_test();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    res(16'h0000);
    rd(A_CT, 8'h00);
    setpoly(16'h1021);
    rd(`PCRC_ADDR_POLY_HI, 8'h10);
    wr(A_CT, 8'h81);
    rd(A_CT, 8'h01);
    wr(A_CT, 8'h00);
    c = 16'hffff;
    res(c);
    for (int i = 0; i < 9; i++) begin
      feed(8'h31 + 8'(i));
      res(c);
    end
    res(16'h29b1);
    for (int m = 0; m < 4; m++) begin
      wr(A_CT, {5'h00, 2'(m), 1'b0});
      res(view(c, 2'(m)));
    end
    wr(A_CT, 8'h00);
    res(c);
    @(posedge clk);
    t_page <= 8'h05;
    wr(`PCRC_ADDR_POLY_LO, 8'h00);
    t_page <= `PCRC_PAGE;
    rd(`PCRC_ADDR_POLY_LO, 8'h21);
    rd(8'hb8, 8'h00);
    wr(A_CT, 8'h80);
    c = 16'h0000;
    setpoly(16'($random(seed)) | 16'h0001);
    repeat (6) feed(8'($random(seed)));
    // lsb-first byte 0xc0 sent already reversed
    feed(8'h03);
    // clock enable dropped for three cycles in mid-fold
    wr(A_IN, 8'h77);
    t_en <= 1'b0;
    repeat (3) @(posedge clk);
    t_en <= 1'b1;
    c = crc8(c, 8'h77);
    idle();
    wr(A_IN, 8'h5a);
    wr(A_IN, 8'ha5);
    c = crc8(c, 8'h5a);
    idle();
    res(c);
    for (int g = 0; g < 2; g++) begin
      wr(A_CT, 8'h80);
      c = 16'h0000;
      bufv <= {32'($random(seed)), 32'($random(seed))};
      gap <= 4'(g * 5);
      wr(A_CT, 8'h08);
      dma_on <= 1'b1;
      for (int i = 0; i < 400; i++) begin
        @(posedge clk);
        if (m_done === 1'b1 && dma_on) break;
      end
      dma_on <= 1'b0;
      wr(A_CT, 8'h00);
      idle();
      for (int i = 0; i < 8; i++) c = crc8(c, bufv[8*i +: 8]);
      res(c);
    end
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    res(16'h0000);
    rd(`PCRC_ADDR_POLY_LO, 8'h00);
    repeat (3) @(posedge clk);
    stop_test();
  end
endmodule : tb_top

// *** verilog/pcrc_defs.svh ***
/*
  Constants of the programmable CRC-16 engine: register addresses, control bit
  positions, seeds and reset values.
  Assumes an 8-bit special-function-register bus with a page select.
*/
// Overview of operation
// - any 16-bit polynomial from poly registers
// - input arrives as bytes written to crc_data_in
// - each byte folds in before next accepted
// - poly bits mean x^15 down to x^0
// - byte shifted in msb first, left
// - clear seeds 0x0000, or 0xffff with seed_select
// - invert_out gives ones complement on reads
// - flip_out reverses all 16 result bits
// - dma_mode starts dma-driven byte feed
// - processor writes processed identically to dma
// - all registers decoded on page 0x2
// - crc_clear self-clears after seeding
`ifndef PCRC_DEFS_SVH
`define PCRC_DEFS_SVH
`define PCRC_PAGE 8'h02
`define PCRC_ADDR_DATA_IN 8'hb9
`define PCRC_ADDR_RES_LO 8'hba
`define PCRC_ADDR_RES_HI 8'hbb
`define PCRC_ADDR_POLY_LO 8'hbc
`define PCRC_ADDR_POLY_HI 8'hbd
`define PCRC_ADDR_CONTROL 8'hbe
`define PCRC_BIT_CLEAR 7
`define PCRC_BIT_DMA 3
`define PCRC_BIT_FLIP 2
`define PCRC_BIT_INV 1
`define PCRC_BIT_SEED 0
`define PCRC_SEED_ZERO 16'h0000
`define PCRC_SEED_ONES 16'hffff
`define PCRC_RESET_BYTE 8'h00
`define PCRC_RESET_WORD 16'h0000
`define PCRC_BITS_PER_BYTE 4'h8
`endif

// *** verilog/pcrc_engine.sv ***
/*
  Byte-serial CRC-16 engine with programmable polynomial, seed, output
  inversion and output bit reversal; bytes come from register writes or from
  a dma channel writing crc_data_in.
  Assumes one clock, an 8-bit register port with read data one cycle late and
  a dma channel that writes crc_data_in only while dma_req is high.
*/
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "pcrc_defs.svh"
module pcrc_engine (
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [7:0] reg_page,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic dma_req,
  output logic busy
);
  logic [15:0] crc_poly;
  logic [15:0] crc_value;
  logic [7:0] shift_byte;
  logic [3:0] bit_count;
  logic [7:0] data_hold;
  logic crc_clear;
  logic dma_mode;
  logic flip_out;
  logic invert_out;
  logic seed_select;
  pcrc_pkg::pcrc_state_t state;
  logic [7:0] rdata;
  logic [15:0] next_crc_poly;
  logic [15:0] next_crc_value;
  logic [7:0] next_shift_byte;
  logic [3:0] next_bit_count;
  logic [7:0] next_data_hold;
  logic next_crc_clear;
  logic next_dma_mode;
  logic next_flip_out;
  logic next_invert_out;
  logic next_seed_select;
  pcrc_pkg::pcrc_state_t next_state;
  logic [7:0] next_rdata;
  logic on_page;
  logic wr_hit_data;
  logic wr_hit_ctrl;
  logic [15:0] view_value;
  logic [15:0] flipped;
  logic feedback;

  // register decode only on the engine page
  assign on_page = (reg_page == `PCRC_PAGE);
  assign wr_hit_data = reg_wr && on_page && (reg_addr == `PCRC_ADDR_DATA_IN);
  assign wr_hit_ctrl = reg_wr && on_page && (reg_addr == `PCRC_ADDR_CONTROL);
  assign busy = (state == pcrc_pkg::PCRC_SHIFT);
  // request a byte whenever idle in dma mode and crc_clear is low
  assign dma_req = dma_mode && !busy && !crc_clear;

  // bit reversal of the raw value for reads
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_flip
      assign flipped[gi] = crc_value[15 - gi];
    end
  endgenerate

  // presented value, raw value untouched
  always_comb begin
    view_value = flip_out ? flipped : crc_value;
    if (invert_out) begin
      view_value = ~view_value;
    end
  end

  // msb of the byte meets msb of the register
  assign feedback = crc_value[15] ^ shift_byte[7];

  // next values of the shifter and registers
  always_comb begin
    next_crc_poly = crc_poly;
    next_crc_value = crc_value;
    next_shift_byte = shift_byte;
    next_bit_count = bit_count;
    next_data_hold = data_hold;
    next_crc_clear = 1'b0;
    next_dma_mode = dma_mode;
    next_flip_out = flip_out;
    next_invert_out = invert_out;
    next_seed_select = seed_select;
    next_state = state;
    case (state)
      pcrc_pkg::PCRC_IDLE: begin
        if (crc_clear) begin
          next_crc_value = seed_select ? `PCRC_SEED_ONES : `PCRC_SEED_ZERO;
        end else if (wr_hit_data) begin
          next_shift_byte = reg_wdata;
          next_data_hold = reg_wdata;
          next_bit_count = `PCRC_BITS_PER_BYTE;
          next_state = pcrc_pkg::PCRC_SHIFT;
        end
      end
      pcrc_pkg::PCRC_SHIFT: begin
        // one bit per cycle, left shift, poly taps x^15..x^0
        next_crc_value = {crc_value[14:0], 1'b0} ^ (feedback ? crc_poly : 16'h0000);
        next_shift_byte = {shift_byte[6:0], 1'b0};
        next_bit_count = bit_count - 4'h1;
        if (bit_count == 4'h1) begin
          next_state = pcrc_pkg::PCRC_IDLE;
        end
      end
      default: begin
        next_state = pcrc_pkg::PCRC_IDLE;
      end
    endcase
    if (reg_wr && on_page) begin
      case (reg_addr)
        `PCRC_ADDR_POLY_LO: next_crc_poly[7:0] = reg_wdata;
        `PCRC_ADDR_POLY_HI: next_crc_poly[15:8] = reg_wdata;
        `PCRC_ADDR_CONTROL: begin
          next_crc_clear = reg_wdata[`PCRC_BIT_CLEAR];
          next_dma_mode = reg_wdata[`PCRC_BIT_DMA];
          next_flip_out = reg_wdata[`PCRC_BIT_FLIP];
          next_invert_out = reg_wdata[`PCRC_BIT_INV];
          next_seed_select = reg_wdata[`PCRC_BIT_SEED];
        end
        default: begin
        end
      endcase
    end
    // clear aborts any byte in flight
    if (wr_hit_ctrl && reg_wdata[`PCRC_BIT_CLEAR]) begin
      next_state = pcrc_pkg::PCRC_IDLE;
      next_bit_count = 4'h0;
    end
  end

  // read data, one cycle after the strobe
  always_comb begin
    next_rdata = 8'h00;
    if (reg_rd && on_page) begin
      case (reg_addr)
        `PCRC_ADDR_DATA_IN: next_rdata = data_hold;
        `PCRC_ADDR_RES_LO: next_rdata = view_value[7:0];
        `PCRC_ADDR_RES_HI: next_rdata = view_value[15:8];
        `PCRC_ADDR_POLY_LO: next_rdata = crc_poly[7:0];
        `PCRC_ADDR_POLY_HI: next_rdata = crc_poly[15:8];
        `PCRC_ADDR_CONTROL: next_rdata = {crc_clear, 3'h0, dma_mode, flip_out,
                                          invert_out, seed_select};
        default: next_rdata = 8'h00;
      endcase
    end
  end
  assign reg_rdata = rdata;

  // state registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      crc_poly <= `PCRC_RESET_WORD;
      crc_value <= `PCRC_RESET_WORD;
      shift_byte <= `PCRC_RESET_BYTE;
      bit_count <= 4'h0;
      data_hold <= `PCRC_RESET_BYTE;
      crc_clear <= 1'b0;
      dma_mode <= 1'b0;
      flip_out <= 1'b0;
      invert_out <= 1'b0;
      seed_select <= 1'b0;
      state <= pcrc_pkg::PCRC_IDLE;
      rdata <= `PCRC_RESET_BYTE;
    end else if (clk_en) begin
      crc_poly <= next_crc_poly;
      crc_value <= next_crc_value;
      shift_byte <= next_shift_byte;
      bit_count <= next_bit_count;
      data_hold <= next_data_hold;
      crc_clear <= next_crc_clear;
      dma_mode <= next_dma_mode;
      flip_out <= next_flip_out;
      invert_out <= next_invert_out;
      seed_select <= next_seed_select;
      state <= next_state;
      rdata <= next_rdata;
    end
  end

  // byte taken then exactly eight shift cycles
  sequence byte_taken_s;
    wr_hit_data && !busy && !crc_clear && clk_en;
  endsequence
  property byte_busy_p;
    @(posedge clk) disable iff (rst)
      byte_taken_s |=> busy;
  endproperty
  byte_busy_a: assert property (byte_busy_p) else $error("byte not taken");

  fold_bound_a: assert property (@(posedge clk) disable iff (rst)
    (byte_taken_s ##1 (clk_en && !wr_hit_ctrl) [*8]) |=> !busy)
    else $error("byte fold not finished in eight cycles");

  seed_ones_a: assert property (@(posedge clk) disable iff (rst)
    (crc_clear && seed_select && clk_en) |=> (crc_value == `PCRC_SEED_ONES))
    else $error("ones seed not loaded");

  seed_zero_a: assert property (@(posedge clk) disable iff (rst)
    (crc_clear && !seed_select && clk_en) |=> (crc_value == `PCRC_SEED_ZERO))
    else $error("zero seed not loaded");

  clear_self_a: assert property (@(posedge clk) disable iff (rst)
    (crc_clear && clk_en && !wr_hit_ctrl) |=> !crc_clear)
    else $error("clear bit stuck");

  dma_req_busy_a: assert property (@(posedge clk) disable iff (rst)
    busy |-> !dma_req)
    else $error("request during fold");

  dma_req_mode_a: assert property (@(posedge clk) disable iff (rst)
    (dma_mode && !busy && !crc_clear) |-> dma_req)
    else $error("request missing in dma mode");

  read_invert_a: assert property (@(posedge clk) disable iff (rst)
    (reg_rd && on_page && reg_addr == `PCRC_ADDR_RES_LO && invert_out && !flip_out
     && clk_en) |=> (reg_rdata == ~$past(crc_value[7:0])))
    else $error("inverted read wrong");

  read_raw_a: assert property (@(posedge clk) disable iff (rst)
    (reg_rd && on_page && reg_addr == `PCRC_ADDR_RES_HI && !invert_out && !flip_out
     && clk_en) |=> (reg_rdata == $past(crc_value[15:8])))
    else $error("raw read wrong");

  read_flip_a: assert property (@(posedge clk) disable iff (rst)
    (reg_rd && on_page && reg_addr == `PCRC_ADDR_RES_LO && flip_out && !invert_out
     && clk_en) |=> (reg_rdata[0] == $past(crc_value[15])))
    else $error("flipped read wrong");

  off_page_a: assert property (@(posedge clk) disable iff (rst)
    (reg_rd && !on_page && clk_en) |=> (reg_rdata == 8'h00))
    else $error("off page read answered");

  // state frozen while the clock enable is low
  freeze_hold_a: assert property (@(posedge clk) disable iff (rst)
    !clk_en |=> ($stable(crc_value) && $stable(bit_count) && $stable(state)
      && $stable(crc_poly) && $stable(reg_rdata)))
    else $error("state moved while clock enable low");

  // a byte written during a fold is dropped
  busy_refuse_a: assert property (@(posedge clk) disable iff (rst)
    (wr_hit_data && busy && clk_en) |=> $stable(data_hold))
    else $error("byte taken during fold");

  // a taken byte loads the shifter and a full count
  byte_load_a: assert property (@(posedge clk) disable iff (rst)
    byte_taken_s |=> (shift_byte == $past(reg_wdata)
      && bit_count == `PCRC_BITS_PER_BYTE))
    else $error("byte not loaded whole");

  // dma request falls with the byte and returns after the fold
  sequence fold_last_s;
    dma_mode && busy && (bit_count == 4'h1) && clk_en && !wr_hit_ctrl;
  endsequence
  req_drop_a: assert property (@(posedge clk) disable iff (rst)
    (byte_taken_s ##0 dma_mode) |=> !dma_req)
    else $error("request stayed up after byte");
  req_back_a: assert property (@(posedge clk) disable iff (rst)
    fold_last_s |=> dma_req)
    else $error("request not back after fold");

  // dma request only in dma mode
  req_mode_off_a: assert property (@(posedge clk) disable iff (rst)
    !dma_mode |-> !dma_req)
    else $error("request outside dma mode");

  // a clear write aborts the fold and raises the clear bit
  clear_abort_a: assert property (@(posedge clk) disable iff (rst)
    (wr_hit_ctrl && reg_wdata[`PCRC_BIT_CLEAR] && clk_en) |=> (!busy && crc_clear))
    else $error("clear did not abort");

  // polynomial high byte lands where written
  poly_load_a: assert property (@(posedge clk) disable iff (rst)
    (reg_wr && on_page && reg_addr == `PCRC_ADDR_POLY_HI && clk_en)
      |=> (crc_poly[15:8] == $past(reg_wdata)))
    else $error("polynomial high byte not loaded");

  // flipped and inverted high result byte
  read_both_a: assert property (@(posedge clk) disable iff (rst)
    (reg_rd && on_page && reg_addr == `PCRC_ADDR_RES_HI && flip_out && invert_out
     && clk_en) |=> (reg_rdata == ~{$past(crc_value[0]), $past(crc_value[1]),
     $past(crc_value[2]), $past(crc_value[3]), $past(crc_value[4]),
     $past(crc_value[5]), $past(crc_value[6]), $past(crc_value[7])}))
    else $error("flipped inverted read wrong");

  // read data is zero outside the answer cycle
  rdata_idle_a: assert property (@(posedge clk) disable iff (rst)
    (!reg_rd && clk_en) |=> (reg_rdata == 8'h00))
    else $error("read data left standing");

  // unused control bits read as zero, dma bit as held
  ctrl_read_a: assert property (@(posedge clk) disable iff (rst)
    (reg_rd && on_page && reg_addr == `PCRC_ADDR_CONTROL && clk_en)
      |=> (reg_rdata[6:4] == 3'h0 && reg_rdata[3] == $past(dma_mode)))
    else $error("control read wrong");

  // data register reads back the last byte taken
  data_echo_a: assert property (@(posedge clk) disable iff (rst)
    (reg_rd && on_page && reg_addr == `PCRC_ADDR_DATA_IN && clk_en)
      |=> (reg_rdata == $past(data_hold)))
    else $error("data register read wrong");
endmodule : pcrc_engine

// *** verilog/pcrc_pkg.sv ***
/*
  Types of the programmable CRC-16 engine.
  Assumes the constants header is included by the design file.
*/
package pcrc_pkg;
  typedef enum logic {PCRC_IDLE, PCRC_SHIFT} pcrc_state_t;
endpackage : pcrc_pkg
